// ===== hdl/tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCC_ADDR_MODE     8'h00
`define TCC_ADDR_ENABLE   8'h04
`define TCC_ADDR_CCR3     8'h08
`define TCC_ADDR_CCR4     8'h0c
`define TCC_ADDR_STATUS   8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
// Each channel owns one byte of the mode register
`define TCC_CH3_BYTE      7:0
`define TCC_CH4_BYTE      15:8
// Within a channel byte, input view
`define TCC_FLD_FILT      7:4
`define TCC_FLD_PSC       3:2
`define TCC_FLD_SEL       1:0
// Within a channel byte, output view
`define TCC_FLD_CMODE     6:4
`define TCC_FLD_BE        3
`define TCC_FLD_FE        2
// Enable register
`define TCC_EN_CH3_BIT    8
`define TCC_EN_CH4_BIT    12
// Status register
`define TCC_ST_FILT3      0
`define TCC_ST_FILT4      1
`define TCC_ST_REF3       2
`define TCC_ST_REF4       3
`define TCC_ST_CAP3       4
`define TCC_ST_CAP4       5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define TCC_MODE_RST      16'h0000
`define TCC_CCR_RST       16'h0000
`define TCC_FAST_DELAY_CYC 3

`endif

// ===== hdl/tcc_pkg.sv
package tcc_pkg;

  // ----------------------------------------------------------------
  // Channel direction and compare modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCC_SEL_OUTPUT = 2'h0,
    TCC_SEL_DIRECT = 2'h1,
    TCC_SEL_CROSS  = 2'h2,
    TCC_SEL_TRIG   = 2'h3
  } tcc_sel_t;

  typedef enum logic [2:0] {
    TCC_CM_FROZEN  = 3'h0,
    TCC_CM_SET     = 3'h1,
    TCC_CM_CLEAR   = 3'h2,
    TCC_CM_TOGGLE  = 3'h3,
    TCC_CM_FORCE_0 = 3'h4,
    TCC_CM_FORCE_1 = 3'h5,
    TCC_CM_PWM1    = 3'h6,
    TCC_CM_PWM2    = 3'h7
  } tcc_cmode_t;

  // ----------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] div_cnt;
    logic [3:0] run;
    logic       cand;
    logic       out;
  } tcc_flt_state_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [1:0] last_code;
    logic       pulse;
  } tcc_psc_state_t;

  typedef struct packed {
    logic [15:0] mode;
    logic        en3;
    logic        en4;
    logic [15:0] pre3;
    logic [15:0] act3;
    logic [15:0] pre4;
    logic [15:0] act4;
    logic        flag3;
    logic        flag4;
    logic        ref3;
    logic        ref4;
    logic        prev3;
    logic        prev4;
    logic        waitreq;
    logic [31:0] rdata;
  } tcc_top_state_t;

endpackage : tcc_pkg

// ===== hdl/tcc_input_filter.sv
`timescale 1ns/1ps
module tcc_input_filter import tcc_pkg::*; (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Filter setting and data
  input  wire logic [3:0] filt_code,
  input  wire logic       sig_in,
  output      logic       sig_out
);

  tcc_flt_state_t st_ff;
  tcc_flt_state_t nxt_st;
  logic [4:0]     div_last;
  logic [3:0]     n_req;
  logic           tick;
  logic [3:0]     run_new;

  // ----------------------------------------------------------------
  // Sampling rate and length
  // ----------------------------------------------------------------
  always_comb begin
    case (filt_code)
      4'h0:    {div_last, n_req} = {5'h00, 4'h1};
      4'h1:    {div_last, n_req} = {5'h00, 4'h2};
      4'h2:    {div_last, n_req} = {5'h00, 4'h4};
      4'h3:    {div_last, n_req} = {5'h00, 4'h8};
      4'h4:    {div_last, n_req} = {5'h01, 4'h6};
      4'h5:    {div_last, n_req} = {5'h01, 4'h8};
      4'h6:    {div_last, n_req} = {5'h03, 4'h6};
      4'h7:    {div_last, n_req} = {5'h03, 4'h8};
      4'h8:    {div_last, n_req} = {5'h07, 4'h6};
      4'h9:    {div_last, n_req} = {5'h07, 4'h8};
      4'ha:    {div_last, n_req} = {5'h0f, 4'h5};
      4'hb:    {div_last, n_req} = {5'h0f, 4'h6};
      4'hc:    {div_last, n_req} = {5'h0f, 4'h8};
      4'hd:    {div_last, n_req} = {5'h1f, 4'h5};
      4'he:    {div_last, n_req} = {5'h1f, 4'h6};
      default: {div_last, n_req} = {5'h1f, 4'h8};
    endcase
  end

  // ----------------------------------------------------------------
  // Consecutive-sample qualification
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st  = st_ff;
    tick    = (st_ff.div_cnt >= div_last);
    run_new = 4'h1;
    nxt_st.div_cnt = tick ? 5'h00 : st_ff.div_cnt + 5'h01;
    if (filt_code == 4'h0) begin
      nxt_st.out  = sig_in;
      nxt_st.cand = sig_in;
      nxt_st.run  = 4'h1;
    end else if (tick) begin
      if (sig_in == st_ff.cand) begin
        run_new = (st_ff.run >= n_req) ? n_req : st_ff.run + 4'h1;
      end
      nxt_st.cand = sig_in;
      nxt_st.run  = run_new;
      if (run_new >= n_req) begin
        nxt_st.out = sig_in;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sig_out = st_ff.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FLT_BYPASS: assert property (@(posedge clock) disable iff (rst)
    (filt_code == 4'h0) |=> (sig_out == $past(sig_in)))
    else $error("filter off did not pass input through");

  AST_FLT_QUAL: assert property (@(posedge clock) disable iff (rst)
    ($past(filt_code) != 4'h0 && $changed(sig_out)) |-> (st_ff.run >= $past(n_req)))
    else $error("filter output changed before N equal samples");

endmodule : tcc_input_filter

// ===== hdl/tcc_capture_prescaler.sv
`timescale 1ns/1ps
module tcc_capture_prescaler import tcc_pkg::*; (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Control
  input  wire logic       enable,
  input  wire logic [1:0] psc_code,
  // Events
  input  wire logic       event_in,
  output      logic       capture
);

  tcc_psc_state_t st_ff;
  tcc_psc_state_t nxt_st;
  logic [2:0]     last_cnt;

  // ----------------------------------------------------------------
  // Event divider
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    last_cnt = 3'((4'h1 << psc_code) - 4'h1);
    nxt_st.pulse     = 1'b0;
    nxt_st.last_code = psc_code;
    if (!enable || psc_code != st_ff.last_code) begin
      nxt_st.cnt = 3'h0;
    end else if (event_in) begin
      if (st_ff.cnt >= last_cnt) begin
        nxt_st.cnt   = 3'h0;
        nxt_st.pulse = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign capture = st_ff.pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PSC_RESTART: assert property (@(posedge clock) disable iff (rst)
    (!enable) |=> (st_ff.cnt == 3'h0 && !capture))
    else $error("prescaler did not restart while disabled");

  AST_PSC_EVERY: assert property (@(posedge clock) disable iff (rst)
    (enable && event_in && psc_code == 2'h0 && st_ff.last_code == 2'h0) |=> capture)
    else $error("code 00 missed a capture");

endmodule : tcc_capture_prescaler

// ===== hdl/tcc_ch34_top.sv
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "tcc_cfg.svh"

// Contract
// - Filter passes a level only after N successive equal samples.
// - Code 0 unfiltered; codes 1-3 full rate with N 2, 4, 8.
// - Codes 4,5 half rate N 6,8; codes 6,7 quarter rate N 6,8.
// - Codes 8,9 sample at one eighth rate with N 6 and 8.
// - Codes 10-12 sample at one sixteenth rate with N 5, 6, 8.
// - Codes 13-15 sample at one thirty-second rate with N 5, 6, 8.
// - Channel 4 filter in bits 15:12, used only when channel 4 is input.
// - Channel 4 prescaler bits 11:10 capture every 1, 2, 4 or 8 events.
// - Channel 4 select bits 9:8: output, input four, input three, trigger.
// - Channel 3 compare mode, buffer, fast fields act only as output.
// - Channel 3 filter and prescaler act only as input, same codes.
// - Channel 3 select bits 1:0: output, input three, input four, trigger.
// - Compare modes: frozen, set, clear, toggle, force low/high, PWM1, PWM2.
// - Buffered compare value loads at update event, else immediately.
// - Fast enable in PWM sets compare level within three cycles of trigger.
module tcc_ch34_top import tcc_pkg::*; (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  // Timer inputs
  input  wire logic        timer_input_three,
  input  wire logic        timer_input_four,
  input  wire logic        internal_trigger_in,
  input  wire logic        trigger_edge,
  input  wire logic        update_event,
  input  wire logic [15:0] counter_value,
  input  wire logic        count_down,
  // Channel results
  output      logic        ch3_output_reference,
  output      logic        ch4_output_reference,
  output      logic        ch3_capture,
  output      logic        ch4_capture
);

  localparam int FAST_MAX = `TCC_FAST_DELAY_CYC;

  tcc_top_state_t st_ff;
  tcc_top_state_t nxt_st;

  logic [7:0]  ch3_cfg;
  logic [7:0]  ch4_cfg;
  logic        ch3_is_in;
  logic        ch4_is_in;
  logic        raw3;
  logic        raw4;
  logic        filt3;
  logic        filt4;
  logic        cap3;
  logic        cap4;
  logic        bus_take;
  logic        wr_done;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  assign ch3_cfg   = st_ff.mode[`TCC_CH3_BYTE];
  assign ch4_cfg   = st_ff.mode[`TCC_CH4_BYTE];
  assign ch3_is_in = (ch3_cfg[`TCC_FLD_SEL] != TCC_SEL_OUTPUT);
  assign ch4_is_in = (ch4_cfg[`TCC_FLD_SEL] != TCC_SEL_OUTPUT);

  always_comb begin
    case (ch3_cfg[`TCC_FLD_SEL])
      TCC_SEL_DIRECT: raw3 = timer_input_three;
      TCC_SEL_CROSS:  raw3 = timer_input_four;
      TCC_SEL_TRIG:   raw3 = internal_trigger_in;
      default:        raw3 = 1'b0;
    endcase
    case (ch4_cfg[`TCC_FLD_SEL])
      TCC_SEL_DIRECT: raw4 = timer_input_four;
      TCC_SEL_CROSS:  raw4 = timer_input_three;
      TCC_SEL_TRIG:   raw4 = internal_trigger_in;
      default:        raw4 = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Input filters and capture prescalers
  // ----------------------------------------------------------------
  // An output channel forces the filter to bypass so stale settings
  // cannot delay the first sample after switching back to input.
  tcc_input_filter u_filt3 (
    .clock     (clock),
    .rst       (rst),
    .filt_code (ch3_is_in ? ch3_cfg[`TCC_FLD_FILT] : 4'h0),
    .sig_in    (raw3),
    .sig_out   (filt3)
  );

  tcc_input_filter u_filt4 (
    .clock     (clock),
    .rst       (rst),
    .filt_code (ch4_is_in ? ch4_cfg[`TCC_FLD_FILT] : 4'h0),
    .sig_in    (raw4),
    .sig_out   (filt4)
  );

  tcc_capture_prescaler u_psc3 (
    .clock    (clock),
    .rst      (rst),
    .enable   (st_ff.en3 && ch3_is_in),
    .psc_code (ch3_cfg[`TCC_FLD_PSC]),
    .event_in (filt3 && !st_ff.prev3),
    .capture  (cap3)
  );

  tcc_capture_prescaler u_psc4 (
    .clock    (clock),
    .rst      (rst),
    .enable   (st_ff.en4 && ch4_is_in),
    .psc_code (ch4_cfg[`TCC_FLD_PSC]),
    .event_in (filt4 && !st_ff.prev4),
    .capture  (cap4)
  );

  // ----------------------------------------------------------------
  // Compare reference
  // ----------------------------------------------------------------
  function automatic logic ref_next(input logic [2:0]  cm,
                                    input logic        fe,
                                    input logic        cur,
                                    input logic [15:0] ccr);
    logic match;
    logic pwm_act;
    match   = (counter_value == ccr);
    pwm_act = count_down ? (counter_value <= ccr) : (counter_value < ccr);
    ref_next = cur;
    case (cm)
      TCC_CM_FROZEN:  ref_next = cur;
      TCC_CM_SET:     ref_next = match ? 1'b1 : cur;
      TCC_CM_CLEAR:   ref_next = match ? 1'b0 : cur;
      TCC_CM_TOGGLE:  ref_next = match ? !cur : cur;
      TCC_CM_FORCE_0: ref_next = 1'b0;
      TCC_CM_FORCE_1: ref_next = 1'b1;
      TCC_CM_PWM1:    ref_next = (fe && trigger_edge) ? 1'b0 : pwm_act;
      TCC_CM_PWM2:    ref_next = (fe && trigger_edge) ? 1'b1 : !pwm_act;
      default:        ref_next = cur;
    endcase
  endfunction : ref_next

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ----------------------------------------------------------------
  // Register bus and channel state
  // ----------------------------------------------------------------
  assign bus_take = (read || write) && st_ff.waitreq;
  assign wr_done  = write && !st_ff.waitreq;

  always_comb begin
    case (address)
      `TCC_ADDR_MODE:   rd_mux = {16'h0000, st_ff.mode};
      `TCC_ADDR_ENABLE: begin
        rd_mux = 32'h0000_0000;
        rd_mux[`TCC_EN_CH3_BIT] = st_ff.en3;
        rd_mux[`TCC_EN_CH4_BIT] = st_ff.en4;
      end
      `TCC_ADDR_CCR3:   rd_mux = {16'h0000, st_ff.pre3};
      `TCC_ADDR_CCR4:   rd_mux = {16'h0000, st_ff.pre4};
      `TCC_ADDR_STATUS: begin
        rd_mux = 32'h0000_0000;
        rd_mux[`TCC_ST_FILT3] = filt3;
        rd_mux[`TCC_ST_FILT4] = filt4;
        rd_mux[`TCC_ST_REF3]  = st_ff.ref3;
        rd_mux[`TCC_ST_REF4]  = st_ff.ref4;
        rd_mux[`TCC_ST_CAP3]  = st_ff.flag3;
        rd_mux[`TCC_ST_CAP4]  = st_ff.flag4;
      end
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.waitreq = 1'b1;
    nxt_st.prev3   = filt3;
    nxt_st.prev4   = filt4;
    if (bus_take) begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata   = read ? rd_mux : 32'h0000_0000;
    end
    // Writes land on the edge where waitrequest is seen low
    if (wr_done) begin
      case (address)
        `TCC_ADDR_MODE:   nxt_st.mode = merge16(st_ff.mode, writedata[15:0], byteenable[1:0]);
        `TCC_ADDR_ENABLE: begin
          if (byteenable[1]) begin
            nxt_st.en3 = writedata[`TCC_EN_CH3_BIT];
            nxt_st.en4 = writedata[`TCC_EN_CH4_BIT];
          end
        end
        `TCC_ADDR_CCR3: begin
          nxt_st.pre3 = merge16(st_ff.pre3, writedata[15:0], byteenable[1:0]);
          if (ch3_is_in || !ch3_cfg[`TCC_FLD_BE]) begin
            nxt_st.act3 = nxt_st.pre3;
          end
        end
        `TCC_ADDR_CCR4: begin
          nxt_st.pre4 = merge16(st_ff.pre4, writedata[15:0], byteenable[1:0]);
          if (ch4_is_in || !ch4_cfg[`TCC_FLD_BE]) begin
            nxt_st.act4 = nxt_st.pre4;
          end
        end
        `TCC_ADDR_STATUS: begin
          if (byteenable[0]) begin
            nxt_st.flag3 = st_ff.flag3 && !writedata[`TCC_ST_CAP3];
            nxt_st.flag4 = st_ff.flag4 && !writedata[`TCC_ST_CAP4];
          end
        end
        default: ;
      endcase
    end
    if (update_event && !ch3_is_in && ch3_cfg[`TCC_FLD_BE]) begin
      nxt_st.act3 = st_ff.pre3;
    end
    if (update_event && !ch4_is_in && ch4_cfg[`TCC_FLD_BE]) begin
      nxt_st.act4 = st_ff.pre4;
    end
    // A capture beats a same-cycle flag clear or register write
    if (cap3) begin
      nxt_st.pre3  = counter_value;
      nxt_st.act3  = counter_value;
      nxt_st.flag3 = 1'b1;
    end
    if (cap4) begin
      nxt_st.pre4  = counter_value;
      nxt_st.act4  = counter_value;
      nxt_st.flag4 = 1'b1;
    end
    if (!ch3_is_in) begin
      nxt_st.ref3 = ref_next(ch3_cfg[`TCC_FLD_CMODE], ch3_cfg[`TCC_FLD_FE],
                             st_ff.ref3, st_ff.act3);
    end
    if (!ch4_is_in) begin
      nxt_st.ref4 = ref_next(ch4_cfg[`TCC_FLD_CMODE], ch4_cfg[`TCC_FLD_FE],
                             st_ff.ref4, st_ff.act4);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff         <= '0;
      st_ff.mode    <= `TCC_MODE_RST;
      st_ff.pre3    <= `TCC_CCR_RST;
      st_ff.act3    <= `TCC_CCR_RST;
      st_ff.pre4    <= `TCC_CCR_RST;
      st_ff.act4    <= `TCC_CCR_RST;
      st_ff.waitreq <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign readdata             = st_ff.rdata;
  assign waitrequest          = st_ff.waitreq;
  assign ch3_output_reference = st_ff.ref3;
  assign ch4_output_reference = st_ff.ref4;
  assign ch3_capture          = cap3;
  assign ch4_capture          = cap4;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_req_taken;
    (read || write) && waitrequest;
  endsequence

  sequence s_one_grant;
    !waitrequest ##1 waitrequest;
  endsequence

  AST_BUS_GRANT: assert property (s_req_taken |=> s_one_grant)
    else $error("bus answer was not a single grant cycle");

  AST_FORCE_LOW3: assert property (
    (!ch3_is_in && ch3_cfg[`TCC_FLD_CMODE] == TCC_CM_FORCE_0) |=> !ch3_output_reference)
    else $error("forced inactive did not drive channel 3 low");

  AST_FAST4: assert property (
    (!ch4_is_in && ch4_cfg[`TCC_FLD_FE] && ch4_cfg[`TCC_FLD_CMODE] == TCC_CM_PWM2
     && trigger_edge) |-> ##[1:FAST_MAX] ch4_output_reference)
    else $error("fast trigger did not reach channel 4 in time");

  AST_BUF3: assert property (
    (update_event && !ch3_is_in && ch3_cfg[`TCC_FLD_BE] && !cap3 && !wr_done)
    |=> (st_ff.act3 == $past(st_ff.pre3)))
    else $error("update event did not load channel 3 buffer");

  AST_CAPT4: assert property (
    cap4 |=> (st_ff.act4 == $past(counter_value) && st_ff.flag4))
    else $error("channel 4 capture did not latch the counter");

  AST_HOLD_IN3: assert property (
    ch3_is_in |=> $stable(ch3_output_reference))
    else $error("channel 3 reference moved while an input");

endmodule : tcc_ch34_top

// ===== tb/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
  // Clock
  input  wire logic clock,
  // Pin levels toward the timer
  output      logic ti3,
  output      logic ti4,
  output      logic trg
);
  initial begin
    ti3 = 1'b0;
    ti4 = 1'b0;
    trg = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pulse trains
  // ----------------------------------------------------------------
  // Trains drive ti3 (sel 3), ti4 (sel 4) or, for an already selected trigger source, trg (sel 0)
  task automatic burst(input int sel, input int hi, input int lo, input int n);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < hi + lo; i++) begin
        @(posedge clock);
        if (sel == 3) ti3 <= (i < hi);
        if (sel == 4) ti4 <= (i < hi);
        if (sel == 0) trg <= (i < hi);
      end
    end
  endtask : burst
endmodule : tcc_pin_model

// ===== tb/tcc_ch34_top_tb.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tcc_ch34_top_tb;
  import tcc_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h3;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        ti3, ti4, trg, ref3, ref4, cap3, cap4;
  logic [31:0] q;
  logic [15:0] cnt_val = 16'h0000;
  logic        cnt_dn = 1'b0;
  logic        trig_edge = 1'b0;
  logic        upd_ev = 1'b0;
  int          err_total = 0;
  int          num_checks = 0;
  int          n3 = 0;
  int          n4 = 0;

  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (cap3 === 1'b1) n3++;
    if (cap4 === 1'b1) n4++;
  end

  tcc_pin_model u_tcc_pin_model (.clock(clock), .ti3(ti3), .ti4(ti4), .trg(trg));
  tcc_ch34_top u_tcc_ch34_top (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timer_input_three(ti3), .timer_input_four(ti4),
    .internal_trigger_in(trg), .trigger_edge(trig_edge), .update_event(upd_ev),
    .counter_value(cnt_val), .count_down(cnt_dn), .ch3_output_reference(ref3),
    .ch4_output_reference(ref4), .ch3_capture(cap3), .ch4_capture(cap4));

  // ----------------------------------------------------------------
  // Bus and setup tasks
  // ----------------------------------------------------------------
  // Waits for the grant however long it takes; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // Channels go off before selects change, as software must
  task automatic cfg(input logic [15:0] mode);
    bus(1'b1, `TCC_ADDR_ENABLE, 32'h0);
    bus(1'b1, `TCC_ADDR_MODE, {16'h0, mode});
    bus(1'b1, `TCC_ADDR_ENABLE, 32'h1100);
    n3 = 0;
    n4 = 0;
  endtask : cfg

  task automatic settle();
    repeat (40) @(posedge clock);
  endtask : settle

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    bus(1'b0, `TCC_ADDR_MODE, 32'h0);
    `CHK("mode_reset", 32'h0, q)
    bus(1'b1, `TCC_ADDR_MODE, 32'hffff_a5c3);
    bus(1'b0, `TCC_ADDR_MODE, 32'h0);
    `CHK("mode_rw", 32'h0000_a5c3, q)
    bus(1'b0, 8'h3c, 32'h0);
    `CHK("unmapped", 32'h0, q)
    $display("test regs done");
  endtask : t_regs

  task automatic t_capture();
    cfg(16'h0001);
    u_tcc_pin_model.burst(3, 3, 3, 3);
    settle();
    `CHK("ch3_every_edge", 3, n3)
    cfg(16'h0009);
    u_tcc_pin_model.burst(3, 3, 3, 9);
    settle();
    `CHK("ch3_div4", 2, n3)
    cfg(16'h0600);
    u_tcc_pin_model.burst(3, 3, 3, 5);
    settle();
    `CHK("ch4_from_three", 2, n4)
    cfg(16'h0f0f);
    u_tcc_pin_model.burst(0, 3, 3, 8);
    settle();
    `CHK("ch3_trig_div8", 1, n3)
    `CHK("ch4_trig_div8", 1, n4)
    bus(1'b0, `TCC_ADDR_STATUS, 32'h0);
    `CHK("cap_flags", 2'b11, q[`TCC_ST_CAP4:`TCC_ST_CAP3])
    bus(1'b1, `TCC_ADDR_STATUS, 32'h0000_0030);
    bus(1'b0, `TCC_ADDR_STATUS, 32'h0);
    `CHK("cap_flags_clear", 2'b00, q[`TCC_ST_CAP4:`TCC_ST_CAP3])
    $display("test capture done");
  endtask : t_capture

  task automatic t_filter();
    cfg(16'h0011);
    u_tcc_pin_model.burst(3, 1, 3, 4);
    settle();
    `CHK("n2_glitch", 0, n3)
    u_tcc_pin_model.burst(3, 3, 3, 3);
    settle();
    `CHK("n2_pass", 3, n3)
    cfg(16'h4100);
    u_tcc_pin_model.burst(4, 8, 30, 2);
    settle();
    `CHK("half_n6_short", 0, n4)
    u_tcc_pin_model.burst(4, 20, 30, 2);
    settle();
    `CHK("half_n6_long", 2, n4)
    $display("test filter done");
  endtask : t_filter

  task automatic t_compare();
    cfg(16'h0050);
    settle();
    `CHK("force_active", 1'b1, ref3)
    cfg(16'h0040);
    settle();
    `CHK("force_inactive", 1'b0, ref3)
    bus(1'b0, `TCC_ADDR_STATUS, 32'h0);
    `CHK("status_ref3", 1'b0, q[`TCC_ST_REF3])
    $display("test compare done");
  endtask : t_compare

  task automatic t_ref();
    cfg(16'h6800);
    bus(1'b1, `TCC_ADDR_CCR4, 32'h0000_0010);
    cnt_val <= 16'h0005;
    settle();
    `CHK("pwm1_before_update", 1'b0, ref4)
    upd_ev <= 1'b1;
    @(posedge clock);
    upd_ev <= 1'b0;
    settle();
    `CHK("pwm1_after_update", 1'b1, ref4)
    bus(1'b0, `TCC_ADDR_CCR4, 32'h0);
    `CHK("ccr4_buffer", 32'h0000_0010, q)
    cnt_val <= 16'h0010;
    cnt_dn <= 1'b1;
    settle();
    `CHK("pwm1_down_equal", 1'b1, ref4)
    cnt_dn <= 1'b0;
    settle();
    `CHK("pwm1_up_equal", 1'b0, ref4)
    cfg(16'h7400);
    cnt_val <= 16'h0000;
    settle();
    `CHK("pwm2_low", 1'b0, ref4)
    trig_edge <= 1'b1;
    @(posedge clock);
    trig_edge <= 1'b0;
    @(posedge clock);
    `CHK("fast_pwm2", 1'b1, ref4)
    @(posedge clock);
    `CHK("fast_pwm2_end", 1'b0, ref4)
    bus(1'b1, `TCC_ADDR_CCR4, 32'h0000_0000);
    settle();
    `CHK("unbuffered_write", 1'b1, ref4)
    // Counter moved off the old compare value first, so no early match
    cnt_val <= 16'h0005;
    cfg(16'h0010);
    settle();
    `CHK("set_no_match", 1'b0, ref3)
    bus(1'b1, `TCC_ADDR_CCR3, 32'h0000_0005);
    settle();
    `CHK("set_on_match", 1'b1, ref3)
    $display("test reference done");
  endtask : t_ref

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_capture();
    t_filter();
    t_compare();
    t_ref();
    close_out();
  end

  // Tests need under 1300 cycles; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    close_out();
  end
endmodule : tcc_ch34_top_tb
